// ==== hdl/uhc_consts.svh ====
// constants for the host command register bits block
`ifndef UHC_CONSTS_SVH
`define UHC_CONSTS_SVH
`define UHC_CMD_OFFSET 8'h20
`define UHC_ITC_LSB 16
`define UHC_ITC_MSB 23
`define UHC_ITC_RESET 8'h08
`define UHC_LRC_BIT 7
`define UHC_DOORBELL_BIT 6
`define UHC_ASE_BIT 5
`define UHC_LRESET_CYCLES 4'h8
`define UHC_LRESET_CNT_W 4
`endif

// ==== hdl/uhc_pkg.sv ====
// types for the host command register bits block
package uhc_pkg;
    // register access from the driver side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } uhc_reg_req_t;

    // light reset sequencer states
    typedef enum logic [1:0] {
        UHC_LR_IDLE = 2'b00,
        UHC_LR_BUSY = 2'b01
    } uhc_lr_state_t;
endpackage : uhc_pkg

// ==== hdl/uhc_command.sv ====
// host command register: light reset, async advance doorbell, async schedule enable
// How it works
// - light reset clears internal controller state, leaving ports and companion ownership alone
// - without light reset support the control bit reads zero
// - light reset bit reads one while reset runs, zero once done
// - once cached schedule state is evicted, the async advance status flag is set
// - status set with irq enable high raises interrupt at next threshold boundary
// - doorbell clears only after the status flag is set, or when a light reset runs
// - schedule enable resets to zero; zero skips async schedule processing
// - schedule enable one fetches async schedule from the list address register
// - threshold field defaults to 08h and sets the maximum interrupt rate
`timescale 1ns/1ps
`include "uhc_consts.svh"

module uhc_command import uhc_pkg::*; #(
    parameter bit LIGHT_RESET_IMPL = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire uhc_reg_req_t req_i,
    input wire logic controller_halted_flag_i,
    input wire logic async_advance_irq_enable_i,
    input wire logic evict_done_i,
    input wire logic async_advance_status_clr_i,
    input wire logic microframe_tick_i,
    input wire logic [31:0] async_list_address_i,
    output logic [31:0] rdata_o,
    output logic async_advance_status_o,
    output logic async_advance_irq_o,
    output logic evict_request_o,
    output logic async_fetch_en_o,
    output logic [31:0] async_fetch_addr_o,
    output logic light_reset_active_o
);
    // decoded command write
    logic cmd_wr;
    // software visible fields
    logic [7:0] itc_q;
    logic ase_q;
    logic doorbell_q;
    // doorbell and status handshake
    logic status_q;
    logic status_set;
    logic status_set_q;
    // interrupt pacing in microframes
    logic irq_q;
    logic [7:0] uframe_cnt_q;
    logic [7:0] uframe_next;
    logic uframe_boundary;
    // light reset sequencing
    uhc_lr_state_t lr_state_q;
    logic [`UHC_LRESET_CNT_W-1:0] lr_cnt_q;
    logic lr_busy_q;
    // read path and schedule steering
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic [31:0] fetch_addr_q;
    logic fetch_en_q;

    // notes for the integrator:
    // the halted flag is only carried here; a threshold write while running lands at once
    // a reserved threshold of zero makes every microframe a boundary
    // a write that lands while the light reset runs is dropped whole, doorbell included
    // ringing the doorbell with the async schedule off is left to the driver to avoid
    // the light reset length is a fixed count of clock cycles, not of microframes

    assign cmd_wr = req_i.wr && (req_i.addr == `UHC_CMD_OFFSET);

    // light reset sequencer; only internal state is touched, ports untouched
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lr_state_q <= UHC_LR_IDLE;
            lr_cnt_q <= '0;
        end else begin
            case (lr_state_q)
                UHC_LR_IDLE: begin
                    if (LIGHT_RESET_IMPL && cmd_wr && req_i.wdata[`UHC_LRC_BIT]) begin
                        lr_state_q <= UHC_LR_BUSY;
                        lr_cnt_q <= `UHC_LRESET_CYCLES;
                    end
                end
                UHC_LR_BUSY: begin
                    if (lr_cnt_q == '0) begin
                        lr_state_q <= UHC_LR_IDLE;
                    end else begin
                        lr_cnt_q <= lr_cnt_q - 1'b1;
                    end
                end
                default: lr_state_q <= UHC_LR_IDLE;
            endcase
        end
    end

    // busy flag in its own flop, so the active output needs no decode behind the state register
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lr_busy_q <= 1'b0;
        end else if (lr_state_q == UHC_LR_IDLE) begin
            lr_busy_q <= LIGHT_RESET_IMPL && cmd_wr && req_i.wdata[`UHC_LRC_BIT];
        end else begin
            lr_busy_q <= (lr_state_q == UHC_LR_BUSY) && (lr_cnt_q != '0);
        end
    end

    // threshold and schedule enable fields; the light reset returns them to defaults
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            itc_q <= `UHC_ITC_RESET;
            ase_q <= 1'b0;
        end else if (lr_state_q == UHC_LR_BUSY) begin
            itc_q <= `UHC_ITC_RESET;
            ase_q <= 1'b0;
        end else if (cmd_wr) begin
            // no guard on halted: a running change is the driver's problem
            itc_q <= req_i.wdata[`UHC_ITC_MSB:`UHC_ITC_LSB];
            ase_q <= req_i.wdata[`UHC_ASE_BIT];
        end
    end

    // doorbell stays up until the status flag has been set or a light reset runs
    // it waits for its own eviction: a flag left standing from an earlier ring does not drop it
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            doorbell_q <= 1'b0;
        end else if (lr_state_q == UHC_LR_BUSY) begin
            doorbell_q <= 1'b0;
        end else if (cmd_wr && req_i.wdata[`UHC_DOORBELL_BIT]) begin
            doorbell_q <= 1'b1;
        end else if (doorbell_q && status_set_q) begin
            doorbell_q <= 1'b0;
        end
    end

    // eviction finished for a standing doorbell; counted even when the flag is already up
    assign status_set = doorbell_q && evict_done_i;

    // status flag: light reset clears it, otherwise a set wins over a software clear
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_q <= 1'b0;
        end else if (lr_state_q == UHC_LR_BUSY) begin
            status_q <= 1'b0;
        end else if (status_set) begin
            status_q <= 1'b1;
        end else if (async_advance_status_clr_i) begin
            status_q <= 1'b0;
        end
    end

    // remembers that this ring has set the flag, so the doorbell drops one cycle later
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_set_q <= 1'b0;
        end else begin
            status_set_q <= status_set && (lr_state_q == UHC_LR_IDLE);
        end
    end

    // next microframe count and threshold boundary; 8 bits cover the largest valid threshold
    assign uframe_next = uframe_cnt_q + 8'h01;
    assign uframe_boundary = microframe_tick_i && (uframe_next >= itc_q);

    // threshold boundary counter in microframes, interrupt raised at boundary
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            uframe_cnt_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            if (uframe_boundary) begin
                uframe_cnt_q <= 8'h00;
                irq_q <= status_q && async_advance_irq_enable_i;
            end else if (microframe_tick_i) begin
                uframe_cnt_q <= uframe_next;
            end
            if (!status_q || !async_advance_irq_enable_i) begin
                irq_q <= 1'b0;
            end
        end
    end

    // schedule fetch steering; disabled enable skips the async list entirely
    // the address is copied every cycle, so a list address update shows one cycle later
    // a light reset forces the fetch off even when an enable write raced it
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fetch_en_q <= 1'b0;
            fetch_addr_q <= 32'h0000_0000;
        end else begin
            fetch_en_q <= ase_q && (lr_state_q == UHC_LR_IDLE);
            fetch_addr_q <= async_list_address_i;
        end
    end

    // read word assembly; reserved bits and other addresses give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (req_i.rd && req_i.addr == `UHC_CMD_OFFSET) begin
            rdata_d[`UHC_ITC_MSB:`UHC_ITC_LSB] = itc_q;
            rdata_d[`UHC_LRC_BIT] = LIGHT_RESET_IMPL && lr_busy_q;
            rdata_d[`UHC_DOORBELL_BIT] = doorbell_q;
            rdata_d[`UHC_ASE_BIT] = ase_q;
        end
    end

    // read data, registered one cycle after the read strobe; zero between reads
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign async_advance_status_o = status_q;
    assign async_advance_irq_o = irq_q;
    assign evict_request_o = doorbell_q;
    assign async_fetch_en_o = fetch_en_q;
    assign async_fetch_addr_o = fetch_addr_q;
    assign light_reset_active_o = lr_busy_q;
endmodule : uhc_command

// ==== sim/uhc_command_properties.sv ====
// port assertions for the host command register bits block
`timescale 1ns/1ps
module uhc_command_properties import uhc_pkg::*; (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire uhc_reg_req_t req_i,
    input wire logic evict_done_i,
    input wire logic async_advance_irq_enable_i,
    input wire logic [31:0] rdata_o,
    input wire logic async_advance_status_o,
    input wire logic async_advance_irq_o,
    input wire logic evict_request_o,
    input wire logic async_fetch_en_o,
    input wire logic light_reset_active_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic rd_c;
    logic wr_c;
    // accepted strobes; writes are dropped while the light reset runs
    assign rd_c = req_i.rd && req_i.addr == 8'h20;
    assign wr_c = req_i.wr && req_i.addr == 8'h20 && !light_reset_active_o;
    property p_rsv; $past(rd_c) |-> rdata_o[15:8] == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
    property p_lrrd; $past(rd_c) |-> rdata_o[7] == $past(light_reset_active_o); endproperty
    a_lrrd: assert property (p_lrrd) else $error("light reset bit wrong");
    property p_lrlen;
        wr_c && req_i.wdata[7] |=> light_reset_active_o [*8] ##1 light_reset_active_o ##1 !light_reset_active_o;
    endproperty
    a_lrlen: assert property (p_lrlen) else $error("light reset length");
    property p_lrclr; $fell(light_reset_active_o) |-> !async_fetch_en_o && !evict_request_o; endproperty
    a_lrclr: assert property (p_lrclr) else $error("light reset left state");
    property p_db; $fell(evict_request_o) |-> $past(async_advance_status_o) || $past(light_reset_active_o); endproperty
    a_db: assert property (p_db) else $error("doorbell fell early");
    property p_sts; evict_request_o && evict_done_i && !light_reset_active_o |=> async_advance_status_o; endproperty
    a_sts: assert property (p_sts) else $error("status not set");
    property p_irq; async_advance_status_o && async_advance_irq_enable_i |->
        ##[0:600] (async_advance_irq_o || !async_advance_status_o); endproperty
    a_irq: assert property (p_irq) else $error("no interrupt");
    property p_ase; wr_c |-> ##2 async_fetch_en_o == $past(req_i.wdata[5], 2); endproperty
    a_ase: assert property (p_ase) else $error("schedule enable wrong");
    c_db: cover property (evict_request_o && evict_done_i);
    c_irq: cover property (async_advance_irq_o);
    c_lr: cover property ($fell(light_reset_active_o));
endmodule : uhc_command_properties
bind uhc_command uhc_command_properties u_uhc_command_properties (.*);

// ==== sim/uhc_engine_model.sv ====
// schedule engine stand-in: evicts after a delay and ticks microframes
`timescale 1ns/1ps
module uhc_engine_model #(parameter int DLY = 3) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic evict_request_i,
    output logic evict_done_o,
    output logic microframe_tick_o
);
    logic [7:0] wait_q;
    logic [1:0] tick_q;
    // done only after DLY cycles of request; a tick every fourth cycle keeps waits short
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_q <= 8'h00;
            tick_q <= 2'h0;
            evict_done_o <= 1'b0;
        end else begin
            wait_q <= evict_request_i ? wait_q + 8'h01 : 8'h00;
            tick_q <= tick_q + 2'h1;
            evict_done_o <= evict_request_i && wait_q >= 8'(DLY);
        end
    end
    assign microframe_tick_o = tick_q == 2'h3;
endmodule : uhc_engine_model

// ==== sim/uhc_command_test.sv ====
// self-checking bench for the host command register bits block
`timescale 1ns/1ps
module uhc_command_test import uhc_pkg::*;;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, clr = 1'b0, ien = 1'b1, done, tick, sts, irq, door, fen, lra;
    uhc_reg_req_t req = '0;
    logic [31:0] rdata, q, faddr;
    int error_cnt = 0, checked = 0, cyc = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    uhc_command u_uhc_command (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_i(req), .controller_halted_flag_i(1'b1),
        .async_advance_irq_enable_i(ien), .evict_done_i(done), .async_advance_status_clr_i(clr),
        .microframe_tick_i(tick), .async_list_address_i(32'h1234_5670), .rdata_o(rdata),
        .async_advance_status_o(sts), .async_advance_irq_o(irq), .evict_request_o(door),
        .async_fetch_en_o(fen), .async_fetch_addr_o(faddr), .light_reset_active_o(lra));
    uhc_engine_model u_uhc_engine_model (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .evict_request_i(door),
        .evict_done_o(done), .microframe_tick_o(tick));
    task automatic complete_run;
        if (error_cnt == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // one register access; read data is registered, so it is taken just after the next edge
    task automatic acc(input logic w, input logic [31:0] d, input logic [7:0] a = 8'h20);
        @(posedge sys_clk_i);
        req <= '{w, !w, a, d};
        @(posedge sys_clk_i);
        req <= '0;
        #1 q = rdata;
    endtask : acc
    // hang guard well above the expected run length
    always @(posedge sys_clk_i) if (++cyc > 3000) begin
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        acc(1'b0, 32'h0);
        chk("reset", 32'h0008_0000, q);
        acc(1'b1, 32'hff08_ff20);
        acc(1'b1, 32'h0000_0000, 8'h24);
        acc(1'b0, 32'h0);
        chk("ase", 32'h0008_0020, q);
        chk("faddr", 32'h1234_5670, faddr);
        chk("fen", 32'h0000_0001, {31'h0, fen});
        acc(1'b1, 32'h0008_0060);
        while (!irq) #10;
        chk("status", 32'h0000_0003, {30'h0, sts, irq});
        acc(1'b0, 32'h0);
        chk("doorbell", 32'h0008_0020, q);
        @(posedge sys_clk_i);
        clr <= 1'b1;
        @(posedge sys_clk_i);
        clr <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        #1 chk("clr", 32'h0, {30'h0, sts, irq});
        // enable low: status still sets, no interrupt until the enable returns
        @(posedge sys_clk_i);
        ien <= 1'b0;
        acc(1'b1, 32'h0008_0060);
        repeat (40) @(posedge sys_clk_i);
        #1 chk("masked irq", 32'h0000_0002, {30'h0, sts, irq});
        @(posedge sys_clk_i);
        ien <= 1'b1;
        repeat (40) @(posedge sys_clk_i);
        #1 chk("late irq", 32'h0000_0003, {30'h0, sts, irq});
        @(posedge sys_clk_i);
        clr <= 1'b1;
        @(posedge sys_clk_i);
        clr <= 1'b0;
        acc(1'b1, 32'h0040_0020);
        acc(1'b0, 32'h0);
        chk("itc", 32'h0040_0020, q);
        acc(1'b1, 32'h0010_0080);
        acc(1'b0, 32'h0);
        chk("lr busy", 32'h0000_0080, q & 32'h0000_0080);
        while (lra) #10;
        acc(1'b0, 32'h0);
        chk("lr done", 32'h0008_0000, q);
        chk("fen off", 32'h0000_0000, {31'h0, fen});
        complete_run();
    end
endmodule : uhc_command_test
